/* rtl/eisc_pkg.sv */
package eisc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] EISC_CTRL_ADDR = 16'h0028;
    localparam logic [7:0] EISC_CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int EISC_TOP_ENABLE_BIT = 0;
    localparam int EISC_TOP_EDGE_BIT = 1;
    localparam int EISC_POL_A_BIT = 2;
    localparam int EISC_SENSE_A_LO = 3;
    localparam int EISC_POL_B_BIT = 5;
    localparam int EISC_SENSE_B_LO = 6;
    localparam logic [7:0] EISC_GUARDED_MASK = 8'hFC;

    // ------------------------------------------------------------
    // pin counts per line
    // ------------------------------------------------------------
    localparam int EISC_LINE0_PINS = 4;
    localparam int EISC_LINE1_PINS = 3;
    localparam int EISC_LINE2_PINS = 4;
    localparam int EISC_LINE3_PINS = 1;
    localparam int EISC_NUM_LINES = 4;

    // ------------------------------------------------------------
    // sensitivity codes
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        EISC_FALL_LOW = 2'b00,
        EISC_RISE_ONLY = 2'b01,
        EISC_FALL_ONLY = 2'b10,
        EISC_BOTH_EDGES = 2'b11
    } eisc_sense_e;

endpackage

/* rtl/eisc_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none
// configuration handed from the register block to one sense detector
interface eisc_cfg_if;
    logic [1:0] sense_sel;
    logic invert;
    logic clear_pending;
    logic ack;
    logic request;
    modport ctrl (output sense_sel, output invert, output clear_pending, output ack,
        input request);
    modport line (input sense_sel, input invert, input clear_pending, input ack,
        output request);
endinterface
`default_nettype wire

/* rtl/eisc_line_sense.sv */
`timescale 1ns/1ps
`default_nettype none
module eisc_line_sense #(
    parameter int PINS = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [PINS-1:0] pin_in,
    eisc_cfg_if.line cfg
);

    typedef struct packed {
        logic [PINS-1:0] sync1;
        logic [PINS-1:0] sync2;
        logic [PINS-1:0] prev;
        logic pending;
    } eisc_line_s;

    eisc_line_s st;
    eisc_line_s next_st;
    logic [PINS-1:0] rise;
    logic [PINS-1:0] fall;
    logic edge_hit;
    logic level_hit;

    // -------------------------------------------------------------
    // trigger decode and pending latch
    // -------------------------------------------------------------
    // sync1 feeds only sync2; detection looks at sync2 and prev
    always_comb
    begin
        next_st = st;
        next_st.sync1 = pin_in;
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;
        rise = st.sync2 & ~st.prev;
        fall = ~st.sync2 & st.prev;
        level_hit = 1'b0;
        // invert swaps rising and falling; both-edges stays symmetric
        case (eisc_pkg::eisc_sense_e'(cfg.sense_sel))
            eisc_pkg::EISC_FALL_LOW:
            begin
                edge_hit = cfg.invert ? |rise : |fall;
                level_hit = cfg.invert ? |st.sync2 : |(~st.sync2);
            end
            eisc_pkg::EISC_RISE_ONLY: edge_hit = cfg.invert ? |fall : |rise;
            eisc_pkg::EISC_FALL_ONLY: edge_hit = cfg.invert ? |rise : |fall;
            eisc_pkg::EISC_BOTH_EDGES: edge_hit = |rise | |fall;
            default: edge_hit = 1'b0;
        endcase
        // a new edge wins over a service ack or a config clear
        if (edge_hit)
        begin
            next_st.pending = 1'b1;
        end
        else if (cfg.ack || cfg.clear_pending)
        begin
            next_st.pending = 1'b0;
        end
        // level mode keeps asking for as long as the level is there
        cfg.request = st.pending | level_hit;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // pins idle high behind pull-ups; a high seed avoids a false edge after reset
            st <= '0;
            st.sync1 <= '1;
            st.sync2 <= '1;
            st.prev <= '1;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule // eisc_line_sense
`default_nettype wire

/* rtl/eisc_top.sv */
// Behaviour
// - four external lines, configured in pairs (0 with 1, 2 with 3) by shared sense fields
// - writing a changed sense or polarity value clears all pending line requests
// - bits 7:6 select sense for line 2 (port B 3..0) and line 3
// - bits 4:3 select sense for line 0 (port A) and line 1 (port F)
// - lines 1,3: 0 fall+low, 1 rise, 2 fall, 3 both edges
// - lines 0,2 inverted: rise+high, fall, rise, both; only they get rise+high
// - bit 5 inverts port B 3..0 sense, bit 2 inverts port A sense
// - bit 1 picks top interrupt edge, changed only while top enable is clear
// - bit 0 enables the top-level interrupt pin, freely written
// - with the top enable clear, an edge raises no new top-level request; one already pending is kept, and an edge in its ack cycle keeps it set
// - control register at 0028h, read/write, resets to zero
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module eisc_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu side
    input wire logic cpu_prio_bit_hi,
    input wire logic cpu_prio_bit_lo,
    input wire logic [4:0] irq_ack,
    // pins
    input wire logic [3:0] port_a_pins,
    input wire logic [2:0] port_f_pins,
    input wire logic [4:0] port_b_pins,
    input wire logic top_irq_pin,
    // requests: bit 4 top level, bits 3..0 lines 3..0
    output logic top_level_interrupt,
    output logic ext_irq_line0,
    output logic ext_irq_line1,
    output logic ext_irq_line2,
    output logic ext_irq_line3
);

    typedef struct packed {
        logic [7:0] ext_irq_control;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic clear_pending;
        logic [1:0] top_sync;
        logic top_prev;
        logic top_pending;
        logic [4:0] irq_out;
    } eisc_top_s;

    eisc_top_s st;
    eisc_top_s next_st;
    logic [3:0] line_req;
    logic [7:0] wr_byte;
    logic at_level3;
    logic setup;
    logic top_edge;

    eisc_cfg_if cfg0();
    eisc_cfg_if cfg1();
    eisc_cfg_if cfg2();
    eisc_cfg_if cfg3();

    // -------------------------------------------------------------
    // field routing to the four lines
    // -------------------------------------------------------------
    // only lines 0 and 2 have polarity inputs wired
    assign cfg0.sense_sel = st.ext_irq_control[eisc_pkg::EISC_SENSE_A_LO +: 2];
    assign cfg1.sense_sel = st.ext_irq_control[eisc_pkg::EISC_SENSE_A_LO +: 2];
    assign cfg2.sense_sel = st.ext_irq_control[eisc_pkg::EISC_SENSE_B_LO +: 2];
    assign cfg3.sense_sel = st.ext_irq_control[eisc_pkg::EISC_SENSE_B_LO +: 2];
    assign cfg0.invert = st.ext_irq_control[eisc_pkg::EISC_POL_A_BIT];
    assign cfg1.invert = 1'b0;
    assign cfg2.invert = st.ext_irq_control[eisc_pkg::EISC_POL_B_BIT];
    assign cfg3.invert = 1'b0;
    assign cfg0.clear_pending = st.clear_pending;
    assign cfg1.clear_pending = st.clear_pending;
    assign cfg2.clear_pending = st.clear_pending;
    assign cfg3.clear_pending = st.clear_pending;
    assign cfg0.ack = irq_ack[0];
    assign cfg1.ack = irq_ack[1];
    assign cfg2.ack = irq_ack[2];
    assign cfg3.ack = irq_ack[3];
    assign line_req = {cfg3.request, cfg2.request, cfg1.request, cfg0.request};

    // -------------------------------------------------------------
    // per-line detectors
    // -------------------------------------------------------------
    eisc_line_sense #(.PINS(eisc_pkg::EISC_LINE0_PINS)) u_line0 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(port_a_pins),
        .cfg(cfg0.line)
    );
    eisc_line_sense #(.PINS(eisc_pkg::EISC_LINE1_PINS)) u_line1 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(port_f_pins),
        .cfg(cfg1.line)
    );
    eisc_line_sense #(.PINS(eisc_pkg::EISC_LINE2_PINS)) u_line2 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(port_b_pins[3:0]),
        .cfg(cfg2.line)
    );
    eisc_line_sense #(.PINS(eisc_pkg::EISC_LINE3_PINS)) u_line3 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(port_b_pins[4]),
        .cfg(cfg3.line)
    );

    // -------------------------------------------------------------
    // apb access, register write rules, top-level edge
    // -------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        setup = psel && !penable;
        at_level3 = cpu_prio_bit_hi && cpu_prio_bit_lo;
        wr_byte = st.ext_irq_control;
        next_st.clear_pending = 1'b0;
        next_st.pready = 1'b0;
        // no wait state: answer registered in the setup cycle, seen in access
        if (setup)
        begin
            next_st.pready = 1'b1;
            next_st.pslverr = (paddr != eisc_pkg::EISC_CTRL_ADDR);
            next_st.prdata = '0;
            if (paddr == eisc_pkg::EISC_CTRL_ADDR && !pwrite)
            begin
                next_st.prdata = {24'h000000, st.ext_irq_control};
            end
        end
        if (psel && penable && st.pready && pwrite && !st.pslverr)
        begin
            // guarded fields hold unless the cpu is masked at level 3
            if (at_level3)
            begin
                wr_byte[7:2] = pwdata[7:2];
            end
            // edge select frozen while the top interrupt is enabled
            if (!st.ext_irq_control[eisc_pkg::EISC_TOP_ENABLE_BIT])
            begin
                wr_byte[eisc_pkg::EISC_TOP_EDGE_BIT] = pwdata[eisc_pkg::EISC_TOP_EDGE_BIT];
            end
            wr_byte[eisc_pkg::EISC_TOP_ENABLE_BIT] = pwdata[eisc_pkg::EISC_TOP_ENABLE_BIT];
            next_st.ext_irq_control = wr_byte;
            next_st.clear_pending = |((wr_byte ^ st.ext_irq_control)
                & eisc_pkg::EISC_GUARDED_MASK);
        end
        // top pin: synchronise, then edge by selected polarity
        next_st.top_sync = {st.top_sync[0], top_irq_pin};
        next_st.top_prev = st.top_sync[1];
        top_edge = st.ext_irq_control[eisc_pkg::EISC_TOP_EDGE_BIT]
            ? (st.top_sync[1] && !st.top_prev) : (!st.top_sync[1] && st.top_prev);
        // detector runs even when disabled; with enable clear an edge raises no request, but keeps a pending one set against irq_ack[4]
        if (top_edge && (st.ext_irq_control[eisc_pkg::EISC_TOP_ENABLE_BIT]
            || st.top_pending))
        begin
            next_st.top_pending = 1'b1;
        end
        else if (irq_ack[4])
        begin
            next_st.top_pending = 1'b0;
        end
        next_st.irq_out = {next_st.top_pending, line_req};
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.ext_irq_control <= eisc_pkg::EISC_CTRL_RESET;
            // top pin idles high too, so its chain starts high
            st.top_sync <= 2'b11;
            st.top_prev <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------
    // outputs straight from flops
    // -------------------------------------------------------------
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign top_level_interrupt = st.irq_out[4];
    assign ext_irq_line0 = st.irq_out[0];
    assign ext_irq_line1 = st.irq_out[1];
    assign ext_irq_line2 = st.irq_out[2];
    assign ext_irq_line3 = st.irq_out[3];

endmodule // eisc_top
`default_nettype wire

/* dv/eisc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checks for the control block
// ----------------------------------------
module eisc_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic top_level_interrupt,
    input wire logic ext_irq_line0
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // the slave never stalls, so every setup is answered in the next cycle
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_has_setup: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    a_err_unmapped: assert property (pready && paddr != 16'h0028 |-> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (pready && paddr == 16'h0028 |-> !pslverr)
        else $error("error on control address");
    a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (pready && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    // requests start clear when reset lets go
    a_reset_quiet: assert property ($rose(rst_n) |-> !top_level_interrupt && !ext_irq_line0)
        else $error("request active after reset");
endmodule // eisc_chk
bind eisc_top eisc_chk u_chk (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .top_level_interrupt, .ext_irq_line0);
`default_nettype wire

/* dv/eisc_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external pins seen by the block
// ----------------------------------------
module eisc_pin_model (
    input wire logic [3:0] line_lvl,
    input wire logic top_lvl,
    output logic [3:0] port_a_pins,
    output logic [2:0] port_f_pins,
    output logic [4:0] port_b_pins,
    output logic top_irq_pin
);
    // a whole line moves at once, so pin merging cannot blur the expected request
    assign port_a_pins = {4{line_lvl[0]}};
    assign port_f_pins = {3{line_lvl[1]}};
    assign port_b_pins = {line_lvl[3], {4{line_lvl[2]}}};
    assign top_irq_pin = top_lvl;
endmodule // eisc_pin_model
`default_nettype wire

/* dv/external_interrupt_sense_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module external_interrupt_sense_control_bench;
    logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic cpu_prio_bit_hi = 1'b1, cpu_prio_bit_lo = 1'b1, top_lvl = 1'b1, pready, pslverr, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0] irq_ack = 5'h00, req, port_b_pins;
    logic [3:0] lvl = 4'hF, pend = 4'h0, port_a_pins;
    logic [2:0] port_f_pins;
    logic top_irq_pin, tpend = 1'b0;
    logic [7:0] ctrl = 8'h00;
    int n_fail = 0, check_count = 0, cyc = 0;

    eisc_top dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cpu_prio_bit_hi, .cpu_prio_bit_lo, .irq_ack, .port_a_pins, .port_f_pins,
        .port_b_pins, .top_irq_pin, .top_level_interrupt(req[4]), .ext_irq_line0(req[0]),
        .ext_irq_line1(req[1]), .ext_irq_line2(req[2]), .ext_irq_line3(req[3]));
    eisc_pin_model u_pins (.line_lvl(lvl), .top_lvl, .port_a_pins, .port_f_pins, .port_b_pins,
        .top_irq_pin);

    initial
    forever #2.5 clk_sys = ~clk_sys;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_of_test();
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one transfer; the global cycle limit cuts a missing pready short
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // polarity and code of one line: lines 1 and 3 never invert
    function automatic logic [2:0] sense(input int i);
        return i == 0 ? {ctrl[2], ctrl[4:3]} : i == 1 ? {1'b0, ctrl[4:3]} :
            i == 2 ? {ctrl[5], ctrl[7:6]} : {1'b0, ctrl[7:6]};
    endfunction

    task automatic cmp();
        logic [4:0] e;
        logic [2:0] s;
        for (int i = 0; i < 4; i++)
        begin
            s = sense(i);
            e[i] = pend[i] | (s[1:0] == 2'h0 && (lvl[i] ^ s[2]) == 1'b0);
        end
        e[4] = tpend;
        check("requests", {27'h0, req}, {27'h0, e});
    endtask

    // guarded bits only land at level 3; bit 1 only while the top enable is clear
    task automatic cfg(input logic [7:0] v, input logic lv3);
        logic [7:0] g;
        g = lv3 ? 8'hFC : 8'h00;
        cpu_prio_bit_hi <= lv3;
        if (((v ^ ctrl) & g) != 8'h00)
            pend = 4'h0;
        ctrl[1] = ctrl[0] ? ctrl[1] : v[1];
        ctrl = {(ctrl[7:2] & ~g[7:2]) | (v[7:2] & g[7:2]), ctrl[1], v[0]};
        apb(1'b1, eisc_pkg::EISC_CTRL_ADDR, {24'h0, v});
        cpu_prio_bit_hi <= 1'b1;
        apb(1'b0, eisc_pkg::EISC_CTRL_ADDR, 32'h0);
        check("ctrl", rd, {24'h0, ctrl});
        repeat (3) @(posedge clk_sys);
        cmp();
    endtask

    task automatic drive(input logic [3:0] nl, input logic nt);
        logic [2:0] s;
        logic a, b;
        for (int i = 0; i < 4; i++)
        begin
            s = sense(i);
            a = lvl[i] ^ s[2];
            b = nl[i] ^ s[2];
            if (s[1:0] == 2'h3 ? a != b : s[1:0] == 2'h1 ? !a && b : a && !b)
                pend[i] = 1'b1;
        end
        if (ctrl[0] && nt != top_lvl && nt == ctrl[1])
            tpend = 1'b1;
        lvl <= nl;
        top_lvl <= nt;
        repeat (10) @(posedge clk_sys);
        cmp();
    endtask

    task automatic ack();
        irq_ack <= 5'h1F;
        @(posedge clk_sys);
        irq_ack <= 5'h00;
        pend = 4'h0;
        tpend = 1'b0;
        repeat (6) @(posedge clk_sys);
        cmp();
    endtask

    // ----------------------------------------
    // hang guard and main sequence
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    initial
    begin
        void'($urandom(32'hb0e7));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, eisc_pkg::EISC_CTRL_ADDR, 32'h0);
        check("ctrl_reset", rd, 32'h0);
        apb(1'b1, 16'h002C, 32'hFF);
        check("unmapped_err", {31'h0, err}, 32'h1);
        apb(1'b0, 16'h002C, 32'h0);
        check("unmapped_read", rd, 32'h0);
        // random modes, some writes refused outside level 3, edges then service
        repeat (24)
        begin
            cfg(8'($urandom) & 8'hFC, ($urandom % 4) != 0);
            drive(4'($urandom), 1'($urandom));
            ack();
        end
        cfg(8'hD8, 1'b1);
        drive(~lvl, top_lvl);
        cfg(8'hD8, 1'b1);
        cfg(8'hDC, 1'b1);
        cfg(8'h02, 1'b1);
        cfg(8'h03, 1'b1);
        drive(lvl, 1'b0);
        drive(lvl, 1'b1);
        ack();
        cfg(8'h01, 1'b1);
        // a top request caught before the enable drops must survive the drop
        drive(lvl, 1'b0);
        drive(lvl, 1'b1);
        cfg(8'h00, 1'b1);
        ack();
        end_of_test();
    end
endmodule // external_interrupt_sense_control_bench
`default_nettype wire
